// ---- design/mpfs_pin_bank.sv ----
// One port's pin bank: port or alternate function per bit, registered drive
`timescale 1ns/100ps
module mpfs_pin_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] dout,
	input wire logic [WIDTH-1:0] alt_sel,
	input wire logic [WIDTH-1:0] alt_out,
	input wire logic [WIDTH-1:0] alt_oe,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] data_in
);
	logic [WIDTH-1:0] out_d, out_q, oe_d, oe_q, in_d, in_q;

	always_comb begin
		out_d = (alt_sel & alt_out) | (~alt_sel & dout);
		oe_d = (alt_sel & alt_oe) | (~alt_sel & dir);
		in_d = pin_in;
		if (sys_rst) begin
			out_d = '0;
			oe_d = '0;
			in_d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		out_q <= out_d;
		oe_q <= oe_d;
		in_q <= in_d;
	end

	assign pin_out = out_q;
	assign pin_oe = oe_q;
	assign data_in = in_q;
endmodule : mpfs_pin_bank

// ---- design/mpfs_pkg.sv ----
// Package of modes, port indices, carriers and reset values for pin function select
package mpfs_pkg;
	// ==========================================================
	// Modes
	typedef enum logic [2:0] {
		MPFS_MODE_NONE,
		MPFS_MODE_1,
		MPFS_MODE_2,
		MPFS_MODE_3,
		MPFS_MODE_4,
		MPFS_MODE_5,
		MPFS_MODE_6,
		MPFS_MODE_7
	} mpfs_mode_t;

	// ==========================================================
	// Port indices into the pin arrays
	localparam int NPORT = 11;
	localparam logic [3:0] P_1 = 4'h0;
	localparam logic [3:0] P_2 = 4'h1;
	localparam logic [3:0] P_3 = 4'h2;
	localparam logic [3:0] P_5 = 4'h3;
	localparam logic [3:0] P_A = 4'h4;
	localparam logic [3:0] P_B = 4'h5;
	localparam logic [3:0] P_C = 4'h6;
	localparam logic [3:0] P_D = 4'h7;
	localparam logic [3:0] P_E = 4'h8;
	localparam logic [3:0] P_F = 4'h9;
	localparam logic [3:0] P_G = 4'ha;

	// ==========================================================
	// Bit positions on shared ports
	localparam int PF_AS = 6;
	localparam int PF_RD = 5;
	localparam int PF_HWR = 4;
	localparam int PF_LWR = 3;
	localparam int PF_WAIT = 2;
	localparam int PF_BACK = 1;
	localparam int PF_BUS_REQUEST_IN = 0;
	localparam int PG_CS0 = 4;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_OUT = 8'h00;
	localparam logic [2:0] RST_MODE = 3'h0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] wdata;
		logic as;
		logic rd;
		logic wr_hi;
		logic wr_lo;
		logic [3:0] area_sel;
		logic [3:0] cs_en;
		logic bus_wide;
		logic released;
		logic bus_request_in_en;
		logic internal_bus_request_out_en;
		logic internal_bus_request_out;
		logic wait_en;
	} mpfs_bus_t;

	typedef struct packed {
		logic we;
		logic is_dir;
		logic [3:0] idx;
		logic [7:0] data;
	} mpfs_port_wr_t;
endpackage : mpfs_pkg

// ---- design/mpfs_top.sv ----
// Mode decode and shared-pin function selection
`timescale 1ns/100ps
module mpfs_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [2:0] mode_select_pins,
	input wire mpfs_pkg::mpfs_bus_t bus_in,
	input wire mpfs_pkg::mpfs_port_wr_t port_wr,
	input wire logic wdt_timer_mode,
	input wire logic wdt_overflow,
	input wire logic [mpfs_pkg::NPORT-1:0][7:0] pins_in,
	input wire logic [3:0] port4_pins,
	output logic [mpfs_pkg::NPORT-1:0][7:0] pins_out,
	output logic [mpfs_pkg::NPORT-1:0][7:0] pins_oe,
	output logic [mpfs_pkg::NPORT-1:0][7:0] port_in,
	output logic [3:0] port4_in,
	output logic [7:0] maskable_request_pins,
	output logic bus_request_in,
	output logic wait_req,
	output logic watchdog_overflow_out_n,
	output mpfs_pkg::mpfs_mode_t mode
);
	// ==========================================================
	// Mode capture
	function automatic mpfs_pkg::mpfs_mode_t mpfs_decode(input logic [2:0] pins);
		// MSB first; pattern zero is unused
		return mpfs_pkg::mpfs_mode_t'(pins);
	endfunction : mpfs_decode

	function automatic logic [7:0] mpfs_width_mask(input int idx);
		case (idx)
			mpfs_pkg::P_3: return 8'h3f;
			mpfs_pkg::P_5: return 8'h0f;
			mpfs_pkg::P_A: return 8'h0f;
			mpfs_pkg::P_G: return 8'h1f;
			default: return 8'hff;
		endcase
	endfunction : mpfs_width_mask

	mpfs_pkg::mpfs_mode_t mode_d, mode_q;
	logic exp_m, adv_m, full_addr;

	// Strap sampled during reset; later changes are ignored
	always_comb begin
		mode_d = mode_q;
		if (sys_rst) begin
			mode_d = mpfs_decode(mode_select_pins);
		end
	end

	always_ff @(posedge clk_sys) begin
		mode_q <= mode_d;
	end

	always_comb begin
		exp_m = 1'b0;
		adv_m = 1'b0;
		full_addr = 1'b0;
		case (mode_q)
			mpfs_pkg::MPFS_MODE_1: begin
				exp_m = 1'b1;
				full_addr = 1'b1;
			end
			mpfs_pkg::MPFS_MODE_2: begin
				exp_m = 1'b1;
			end
			mpfs_pkg::MPFS_MODE_4, mpfs_pkg::MPFS_MODE_5: begin
				exp_m = 1'b1;
				adv_m = 1'b1;
				full_addr = 1'b1;
			end
			mpfs_pkg::MPFS_MODE_6: begin
				exp_m = 1'b1;
				adv_m = 1'b1;
			end
			default: begin
				exp_m = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Port data and direction flip-flops
	logic [mpfs_pkg::NPORT-1:0][7:0] dir_d, dir_q, out_d, out_q;

	always_comb begin
		dir_d = dir_q;
		out_d = out_q;
		for (int i = 0; i < mpfs_pkg::NPORT; i++) begin
			if (port_wr.we && port_wr.idx == 4'(i)) begin
				// Unimplemented bits of narrow ports stay zero
				if (port_wr.is_dir) begin
					dir_d[i] = port_wr.data & mpfs_width_mask(i);
				end else begin
					out_d[i] = port_wr.data & mpfs_width_mask(i);
				end
			end
		end
		if (sys_rst) begin
			dir_d = {mpfs_pkg::NPORT{mpfs_pkg::RST_DIR}};
			out_d = {mpfs_pkg::NPORT{mpfs_pkg::RST_OUT}};
		end
	end

	always_ff @(posedge clk_sys) begin
		dir_q <= dir_d;
		out_q <= out_d;
	end

	// ==========================================================
	// Alternate functions per port
	logic [mpfs_pkg::NPORT-1:0][7:0] alt_sel, alt_out, alt_oe;
	logic address_strobe_n, read_strobe_n, high_byte_write_n, low_byte_write_n;
	logic [3:0] area_select_n;

	always_comb begin
		address_strobe_n = ~bus_in.as;
		read_strobe_n = ~bus_in.rd;
		high_byte_write_n = ~bus_in.wr_hi;
		low_byte_write_n = ~bus_in.wr_lo;
		area_select_n = ~(bus_in.area_sel & bus_in.cs_en);
		alt_sel = '0;
		alt_out = '0;
		alt_oe = '0;
		// Upper address lines: modes 4-6 only; port A all four in modes 4-5, otherwise where the direction bits enable them
		if (adv_m) begin
			alt_sel[mpfs_pkg::P_1][3:0] = dir_q[mpfs_pkg::P_1][3:0];
			alt_sel[mpfs_pkg::P_A][3:0] = full_addr ? 4'hf : dir_q[mpfs_pkg::P_A][3:0];
		end
		alt_out[mpfs_pkg::P_1][3:0] = bus_in.addr[23:20];
		alt_out[mpfs_pkg::P_A][3:0] = bus_in.addr[19:16];
		alt_oe[mpfs_pkg::P_1][3:0] = 4'hf;
		alt_oe[mpfs_pkg::P_A][3:0] = 4'hf;
		if (exp_m) begin
			alt_sel[mpfs_pkg::P_B] = full_addr ? 8'hff : dir_q[mpfs_pkg::P_B];
			alt_sel[mpfs_pkg::P_C] = full_addr ? 8'hff : dir_q[mpfs_pkg::P_C];
			alt_sel[mpfs_pkg::P_D] = 8'hff;
			alt_sel[mpfs_pkg::P_E] = bus_in.bus_wide ? 8'hff : 8'h00;
			alt_sel[mpfs_pkg::P_F][6:3] = 4'hf;
			alt_sel[mpfs_pkg::P_F][mpfs_pkg::PF_WAIT] = bus_in.wait_en | bus_in.internal_bus_request_out_en;
			alt_sel[mpfs_pkg::P_F][mpfs_pkg::PF_BACK] = bus_in.bus_request_in_en;
			alt_sel[mpfs_pkg::P_F][mpfs_pkg::PF_BUS_REQUEST_IN] = bus_in.bus_request_in_en;
			alt_sel[mpfs_pkg::P_G][mpfs_pkg::PG_CS0] = bus_in.cs_en[0];
			if (adv_m) begin
				alt_sel[mpfs_pkg::P_G][3:1] = {bus_in.cs_en[1], bus_in.cs_en[2], bus_in.cs_en[3]};
			end
		end
		alt_out[mpfs_pkg::P_B] = bus_in.addr[15:8];
		alt_out[mpfs_pkg::P_C] = bus_in.addr[7:0];
		alt_oe[mpfs_pkg::P_B] = 8'hff;
		alt_oe[mpfs_pkg::P_C] = 8'hff;
		// Data lanes driven only while writing their byte
		alt_out[mpfs_pkg::P_D] = bus_in.wdata[15:8];
		alt_out[mpfs_pkg::P_E] = bus_in.wdata[7:0];
		alt_oe[mpfs_pkg::P_D] = {8{bus_in.wr_hi}};
		alt_oe[mpfs_pkg::P_E] = {8{bus_in.wr_lo}};
		alt_out[mpfs_pkg::P_F][6:3] = {address_strobe_n, read_strobe_n,
			high_byte_write_n, low_byte_write_n};
		alt_oe[mpfs_pkg::P_F][6:3] = 4'hf;
		// Bus-request output wins the shared pin over wait input
		alt_out[mpfs_pkg::P_F][mpfs_pkg::PF_WAIT] = ~bus_in.internal_bus_request_out;
		alt_oe[mpfs_pkg::P_F][mpfs_pkg::PF_WAIT] = bus_in.internal_bus_request_out_en;
		alt_out[mpfs_pkg::P_F][mpfs_pkg::PF_BACK] = ~bus_in.released;
		alt_oe[mpfs_pkg::P_F][mpfs_pkg::PF_BACK] = 1'b1;
		// Area 0 sits on the top bit, area 3 on bit 1
		alt_out[mpfs_pkg::P_G][4:1] = {area_select_n[0], area_select_n[1],
			area_select_n[2], area_select_n[3]};
		alt_oe[mpfs_pkg::P_G][4:1] = 4'hf;
	end

	// ==========================================================
	// Pin banks
	for (genvar g = 0; g < mpfs_pkg::NPORT; g++) begin : g_bank
		mpfs_pin_bank #(
			.WIDTH(8)
		) u_bank (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.dir(dir_q[g]),
			.dout(out_q[g]),
			.alt_sel(alt_sel[g] & mpfs_width_mask(g)),
			.alt_out(alt_out[g]),
			.alt_oe(alt_oe[g] & mpfs_width_mask(g)),
			.pin_in(pins_in[g] & mpfs_width_mask(g)),
			.pin_out(pins_out[g]),
			.pin_oe(pins_oe[g]),
			.data_in(port_in[g])
		);
	end

	// ==========================================================
	// Inputs, requests and watchdog
	logic [3:0] p4_d, p4_q;
	logic [7:0] irq_d, irq_q;
	logic bus_request_in_d, bus_request_in_q, wait_d, wait_q, wdo_d, wdo_q;

	always_comb begin
		p4_d = port4_pins;
		irq_d = {pins_in[mpfs_pkg::P_G][1:0], pins_in[mpfs_pkg::P_3][5:4],
			pins_in[mpfs_pkg::P_F][3:0]};
		if (exp_m) begin
			irq_d[3] = 1'b1;
		end
		bus_request_in_d = exp_m & bus_in.bus_request_in_en & ~pins_in[mpfs_pkg::P_F][mpfs_pkg::PF_BUS_REQUEST_IN];
		// Core applies wait only to three-state external cycles
		wait_d = exp_m & bus_in.wait_en & ~bus_in.internal_bus_request_out_en
			& ~pins_in[mpfs_pkg::P_F][mpfs_pkg::PF_WAIT];
		wdo_d = ~(wdt_timer_mode & wdt_overflow);
		if (sys_rst) begin
			p4_d = '0;
			irq_d = 8'hff;
			bus_request_in_d = 1'b0;
			wait_d = 1'b0;
			wdo_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		p4_q <= p4_d;
		irq_q <= irq_d;
		bus_request_in_q <= bus_request_in_d;
		wait_q <= wait_d;
		wdo_q <= wdo_d;
	end

	assign port4_in = p4_q;
	assign maskable_request_pins = irq_q;
	assign bus_request_in = bus_request_in_q;
	assign wait_req = wait_q;
	assign watchdog_overflow_out_n = wdo_q;
	assign mode = mode_q;

	// ==========================================================
	// Checks
	property p_mode;
		@(posedge clk_sys) sys_rst |=> mode_q == mpfs_pkg::mpfs_mode_t'($past(mode_select_pins));
	endproperty
	a_mode: assert property (p_mode) else $error("mode not captured");

	property p_as;
		@(posedge clk_sys) disable iff (sys_rst)
			(exp_m && bus_in.as) |=> !pins_out[mpfs_pkg::P_F][6] && pins_oe[mpfs_pkg::P_F][6];
	endproperty
	a_as: assert property (p_as) else $error("address strobe not low");

	property p_rd;
		@(posedge clk_sys) disable iff (sys_rst)
			(exp_m && !bus_in.rd) |=> pins_out[mpfs_pkg::P_F][5];
	endproperty
	a_rd: assert property (p_rd) else $error("read strobe low when idle");

	property p_hwr;
		@(posedge clk_sys) disable iff (sys_rst)
			(exp_m && bus_in.wr_hi) |=> !pins_out[mpfs_pkg::P_F][4]
			&& pins_oe[mpfs_pkg::P_D] == 8'hff;
	endproperty
	a_hwr: assert property (p_hwr) else $error("high write lane wrong");

	property p_lwr;
		@(posedge clk_sys) disable iff (sys_rst)
			(exp_m && bus_in.wr_lo) |=> !pins_out[mpfs_pkg::P_F][3];
	endproperty
	a_lwr: assert property (p_lwr) else $error("low write strobe not low");

	property p_back;
		@(posedge clk_sys) disable iff (sys_rst)
			(exp_m && bus_in.bus_request_in_en) |=> pins_out[mpfs_pkg::P_F][1] == !$past(bus_in.released);
	endproperty
	a_back: assert property (p_back) else $error("acknowledge wrong");

	property p_cs0;
		@(posedge clk_sys) disable iff (sys_rst)
			(exp_m && bus_in.cs_en[0]) |=> pins_out[mpfs_pkg::P_G][4] == !$past(bus_in.area_sel[0]);
	endproperty
	a_cs0: assert property (p_cs0) else $error("area select 0 wrong");

	property p_wdo;
		@(posedge clk_sys) disable iff (sys_rst)
			(wdt_timer_mode && wdt_overflow) |=> !watchdog_overflow_out_n;
	endproperty
	a_wdo: assert property (p_wdo) else $error("overflow not shown");

	property p_maskable_request_three;
		@(posedge clk_sys) disable iff (sys_rst) exp_m |=> maskable_request_pins[3];
	endproperty
	a_maskable_request_three: assert property (p_maskable_request_three) else $error("request three active");

	property p_single;
		@(posedge clk_sys) disable iff (sys_rst)
			!exp_m |=> pins_oe[mpfs_pkg::P_D] == $past(dir_q[mpfs_pkg::P_D]);
	endproperty
	a_single: assert property (p_single) else $error("bus pin in single chip");

	property p_narrow;
		@(posedge clk_sys) disable iff (sys_rst) pins_oe[mpfs_pkg::P_3][7:6] == 2'h0;
	endproperty
	a_narrow: assert property (p_narrow) else $error("absent port bit driven");

	c_write: cover property (@(posedge clk_sys) exp_m && bus_in.wr_hi && bus_in.wr_lo);
	c_release: cover property (@(posedge clk_sys) exp_m && bus_in.released);
	c_single: cover property (@(posedge clk_sys) mode_q == mpfs_pkg::MPFS_MODE_7);
	c_wdo: cover property (@(posedge clk_sys) !watchdog_overflow_out_n);
endmodule : mpfs_top

// ---- sim/mpfs_ext_model.sv ----
// Far-side model: external memory and peripherals resolving the shared pins
`timescale 1ns/100ps
module mpfs_ext_model (
	input wire logic [mpfs_pkg::NPORT-1:0][7:0] pins_out,
	input wire logic [mpfs_pkg::NPORT-1:0][7:0] pins_oe,
	input wire logic [mpfs_pkg::NPORT-1:0][7:0] ext_lvl,
	input wire logic [mpfs_pkg::NPORT-1:0][7:0] ext_en,
	input wire logic wait_want,
	output logic [mpfs_pkg::NPORT-1:0][7:0] pins_in
);
	logic strobe_on;
	// ==========================================================
	// Pin resolution
	always_comb begin
		strobe_on = pins_oe[mpfs_pkg::P_F][mpfs_pkg::PF_RD] & ~pins_out[mpfs_pkg::P_F][mpfs_pkg::PF_RD];
		for (int p = 0; p < mpfs_pkg::NPORT; p++) begin
			for (int b = 0; b < 8; b++) begin
				// Undriven pins sit at the board pull-up, never at a stale value
				pins_in[p][b] = pins_oe[p][b] ? pins_out[p][b] : (ext_en[p][b] ? ext_lvl[p][b] : 1'b1);
			end
		end
		// Wait held off unless an external read is in progress
		if (wait_want && strobe_on && !pins_oe[mpfs_pkg::P_F][mpfs_pkg::PF_WAIT]) begin
			pins_in[mpfs_pkg::P_F][mpfs_pkg::PF_WAIT] = 1'b0;
		end
	end
endmodule : mpfs_ext_model

// ---- sim/mpfs_tb_top.sv ----
// Self-checking testbench for mode decode and pin function select
`timescale 1ns/100ps
module mpfs_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] mode_select_pins = 3'h0;
	mpfs_pkg::mpfs_bus_t bus = '0;
	mpfs_pkg::mpfs_port_wr_t pwr = '0;
	logic wdt_timer_mode = 1'b0;
	logic wdt_overflow = 1'b0;
	logic [3:0] port4_pins = 4'h0;
	logic wait_want = 1'b0;
	logic [mpfs_pkg::NPORT-1:0][7:0] ext_lvl = '0;
	logic [mpfs_pkg::NPORT-1:0][7:0] ext_en = '0;
	logic [mpfs_pkg::NPORT-1:0][7:0] pins_in, pins_out, pins_oe, port_in;
	logic [3:0] port4_in;
	logic [7:0] irq;
	logic bus_request_in_in, wait_req, wdo_n;
	mpfs_pkg::mpfs_mode_t mode;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;

	mpfs_top i_mpfs_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode_select_pins(mode_select_pins),
		.bus_in(bus), .port_wr(pwr), .wdt_timer_mode(wdt_timer_mode), .wdt_overflow(wdt_overflow),
		.pins_in(pins_in), .port4_pins(port4_pins), .pins_out(pins_out), .pins_oe(pins_oe),
		.port_in(port_in), .port4_in(port4_in), .maskable_request_pins(irq),
		.bus_request_in(bus_request_in_in), .wait_req(wait_req), .watchdog_overflow_out_n(wdo_n), .mode(mode));
	mpfs_ext_model i_mpfs_ext_model (.pins_out(pins_out), .pins_oe(pins_oe), .ext_lvl(ext_lvl),
		.ext_en(ext_en), .wait_want(wait_want), .pins_in(pins_in));

	// ==========================================================
	// Clock, timeout and shared tasks
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t pin value %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_mode(input mpfs_pkg::mpfs_mode_t got, input mpfs_pkg::mpfs_mode_t exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t mode %h expected %h", $time, got, exp);
		end
	endtask : chk_mode

	// Straps only move inside reset
	task automatic do_reset(input logic [2:0] m);
		@(negedge clk_sys);
		sys_rst = 1'b1;
		mode_select_pins = m;
		bus = '0;
		ext_en = '0;
		wait_want = 1'b0;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
	endtask : do_reset

	// Long enough for both the one- and two-edge latencies
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : settle

	task automatic wr_port(input logic is_dir, input logic [3:0] idx, input logic [7:0] data);
		@(negedge clk_sys);
		pwr = '{we: 1'b1, is_dir: is_dir, idx: idx, data: data};
		@(negedge clk_sys);
		pwr.we = 1'b0;
	endtask : wr_port

	// ==========================================================
	// Scenarios
	task automatic t_modes();
		for (int m = 0; m < 8; m++) begin
			do_reset(3'(m));
			chk_mode(mode, mpfs_pkg::mpfs_mode_t'(m));
		end
		chk(pins_oe[mpfs_pkg::P_F], 8'h00);
		chk(irq, 8'hff);
		$display("test modes done");
	endtask : t_modes

	task automatic t_read_release();
		do_reset(3'h1);
		bus.as = 1'b1;
		bus.rd = 1'b1;
		bus.addr = 24'h12a5c3;
		bus.area_sel = 4'h1;
		bus.cs_en = 4'h1;
		settle();
		chk(pins_out[mpfs_pkg::P_F] & 8'h60, 8'h00);
		chk(pins_oe[mpfs_pkg::P_F] & 8'h60, 8'h60);
		chk(pins_out[mpfs_pkg::P_B], 8'ha5);
		chk(pins_out[mpfs_pkg::P_C], 8'hc3);
		chk(pins_oe[mpfs_pkg::P_A], 8'h00);
		chk(pins_out[mpfs_pkg::P_G] & 8'h10, 8'h00);
		chk(pins_oe[mpfs_pkg::P_G] & 8'h10, 8'h10);
		wait_want = 1'b1;
		bus.wait_en = 1'b1;
		settle();
		chk({7'h0, wait_req}, 8'h01);
		bus.rd = 1'b0;
		bus.as = 1'b0;
		settle();
		chk(pins_out[mpfs_pkg::P_F] & 8'h60, 8'h60);
		chk({7'h0, wait_req}, 8'h00);
		bus.released = 1'b1;
		bus.bus_request_in_en = 1'b1;
		ext_en[mpfs_pkg::P_F][mpfs_pkg::PF_BUS_REQUEST_IN] = 1'b1;
		ext_lvl[mpfs_pkg::P_F][mpfs_pkg::PF_BUS_REQUEST_IN] = 1'b0;
		settle();
		chk(pins_out[mpfs_pkg::P_F] & 8'h02, 8'h00);
		chk(pins_oe[mpfs_pkg::P_F] & 8'h02, 8'h02);
		chk({7'h0, bus_request_in_in}, 8'h01);
		$display("test read_release done");
	endtask : t_read_release

	task automatic t_write();
		do_reset(3'h4);
		bus.wr_hi = 1'b1;
		bus.wr_lo = 1'b1;
		bus.bus_wide = 1'b1;
		bus.wdata = 16'h5a3c;
		bus.addr = 24'h3b1234;
		bus.area_sel = 4'h8;
		bus.cs_en = 4'h8;
		ext_en[mpfs_pkg::P_G][0] = 1'b1;
		ext_lvl[mpfs_pkg::P_G][0] = 1'b0;
		settle();
		chk(pins_out[mpfs_pkg::P_F] & 8'h18, 8'h00);
		chk(pins_oe[mpfs_pkg::P_F] & 8'h18, 8'h18);
		chk(pins_out[mpfs_pkg::P_D], 8'h5a);
		chk(pins_oe[mpfs_pkg::P_D], 8'hff);
		chk(pins_out[mpfs_pkg::P_E], 8'h3c);
		chk(pins_oe[mpfs_pkg::P_E], 8'hff);
		chk(pins_out[mpfs_pkg::P_A] & 8'h0f, 8'h0b);
		chk(pins_out[mpfs_pkg::P_G] & 8'h02, 8'h00);
		chk(pins_oe[mpfs_pkg::P_G] & 8'h12, 8'h02);
		// Request 7 reads the area 3 select it shares a pin with
		chk(irq, 8'h3f);
		bus.bus_wide = 1'b0;
		settle();
		chk(pins_oe[mpfs_pkg::P_E], 8'h00);
		$display("test write done");
	endtask : t_write

	task automatic t_single();
		do_reset(3'h7);
		bus.as = 1'b1;
		bus.rd = 1'b1;
		ext_en[mpfs_pkg::P_F][3] = 1'b1;
		ext_lvl[mpfs_pkg::P_F][3] = 1'b0;
		port4_pins = 4'ha;
		wr_port(1'b1, mpfs_pkg::P_1, 8'hff);
		wr_port(1'b0, mpfs_pkg::P_1, 8'h96);
		wr_port(1'b1, mpfs_pkg::P_3, 8'hff);
		settle();
		chk(pins_oe[mpfs_pkg::P_F], 8'h00);
		// Port 3 bits 5:4 are now outputs driving low
		chk(irq, 8'hc7);
		chk(pins_oe[mpfs_pkg::P_1], 8'hff);
		chk(pins_out[mpfs_pkg::P_1], 8'h96);
		chk(pins_oe[mpfs_pkg::P_3], 8'h3f);
		chk(port_in[mpfs_pkg::P_5], 8'h0f);
		chk({4'h0, port4_in}, 8'h0a);
		$display("test single done");
	endtask : t_single

	task automatic t_mode6();
		do_reset(3'h6);
		wr_port(1'b1, mpfs_pkg::P_B, 8'h0f);
		wr_port(1'b1, mpfs_pkg::P_A, 8'h03);
		bus.addr = 24'h7d5a96;
		bus.internal_bus_request_out_en = 1'b1;
		bus.internal_bus_request_out = 1'b1;
		bus.wait_en = 1'b1;
		wait_want = 1'b1;
		settle();
		chk(pins_oe[mpfs_pkg::P_B], 8'h0f);
		chk(pins_out[mpfs_pkg::P_B], 8'h0a);
		chk(pins_oe[mpfs_pkg::P_A], 8'h03);
		chk(pins_out[mpfs_pkg::P_A], 8'h01);
		chk(pins_oe[mpfs_pkg::P_C], 8'h00);
		chk(pins_out[mpfs_pkg::P_F] & 8'h04, 8'h00);
		chk(pins_oe[mpfs_pkg::P_F] & 8'h04, 8'h04);
		chk({7'h0, wait_req}, 8'h00);
		$display("test mode6 done");
	endtask : t_mode6

	task automatic t_watchdog();
		wdt_overflow = 1'b1;
		settle();
		chk({7'h0, wdo_n}, 8'h01);
		wdt_timer_mode = 1'b1;
		settle();
		chk({7'h0, wdo_n}, 8'h00);
		wdt_overflow = 1'b0;
		settle();
		chk({7'h0, wdo_n}, 8'h01);
		$display("test watchdog done");
	endtask : t_watchdog

	// ==========================================================
	// Main sequence
	initial begin
		t_modes();
		t_read_release();
		t_write();
		t_mode6();
		t_single();
		t_watchdog();
		conclude();
	end
endmodule : mpfs_tb_top
